//--- logic/hdlc_slot_pkg.sv
// ==========================================================================
// register map and field layout of the hdlc timeslot selector
// ==========================================================================
package hdlc_slot_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_FRAMERS = 2;
    localparam int NUM_SLOTS = 24;
    localparam int SLOT_W = 5;
    localparam int BIT_IDX_W = 3;

    // receive mask registers sit just below the transmit control registers
    localparam logic [ADDR_W-1:0] RX_MASK_A_ADDR = 8'h91;
    localparam logic [ADDR_W-1:0] TX_CTRL_A_ADDR = 8'h92;
    localparam logic [ADDR_W-1:0] TX_MASK_A_ADDR = 8'h93;
    localparam logic [ADDR_W-1:0] RX_MASK_B_ADDR = 8'h95;
    localparam logic [ADDR_W-1:0] TX_CTRL_B_ADDR = 8'h96;
    localparam logic [ADDR_W-1:0] TX_MASK_B_ADDR = 8'h97;

    // fields of tx_slot_control
    localparam int TX_SLOT_HDLC_ENABLE_POS = 7;
    localparam int TX_SLOT_SELECT_MODE_POS = 5;
    localparam int TX_CHANNEL_NUM_MSB_POS = 4;
    localparam int TX_CHANNEL_NUM_LSB_POS = 0;
    // bit 6 is not assigned and always reads back as zero
    localparam logic [DATA_W-1:0] TX_CTRL_WMASK = 8'hbf;

    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

endpackage : hdlc_slot_pkg

//--- logic/hdlc_slot_gate.sv
`timescale 1ns/1ns
// ==========================================================================
// per-framer decision: does the current ds0 bit belong to the hdlc stream
// ==========================================================================
module hdlc_slot_gate (
    input wire logic [hdlc_slot_pkg::DATA_W-1:0] tx_ctrl,
    input wire logic [hdlc_slot_pkg::DATA_W-1:0] tx_mask,
    input wire logic [hdlc_slot_pkg::DATA_W-1:0] rx_mask,
    input wire logic [hdlc_slot_pkg::SLOT_W-1:0] tx_slot,
    input wire logic [hdlc_slot_pkg::BIT_IDX_W-1:0] tx_bit,
    input wire logic tx_block_flag,
    input wire logic [hdlc_slot_pkg::BIT_IDX_W-1:0] rx_bit,
    input wire logic rx_slot_sel,
    output logic tx_use,
    output logic rx_use
);

    // index k of a mask register guards ds0 bit k+1; a set bit keeps it out
    function automatic logic bit_free(input logic [hdlc_slot_pkg::DATA_W-1:0] mask,
                                      input logic [hdlc_slot_pkg::BIT_IDX_W-1:0] idx);
        bit_free = !mask[idx];
    endfunction : bit_free

    logic tx_enable;
    logic tx_block_mode;
    logic [hdlc_slot_pkg::SLOT_W-1:0] tx_channel_num;
    logic tx_slot_hit;

    // slot choice: single numbered channel or the channel-block flags
    always_comb begin
        tx_enable = tx_ctrl[hdlc_slot_pkg::TX_SLOT_HDLC_ENABLE_POS];
        tx_block_mode = tx_ctrl[hdlc_slot_pkg::TX_SLOT_SELECT_MODE_POS];
        tx_channel_num = tx_ctrl[hdlc_slot_pkg::TX_CHANNEL_NUM_MSB_POS:
                                 hdlc_slot_pkg::TX_CHANNEL_NUM_LSB_POS]; // see [R2]
        tx_slot_hit = tx_block_mode ? tx_block_flag : (tx_slot == tx_channel_num); // see [R2]
        tx_use = tx_enable && tx_slot_hit && bit_free(tx_mask, tx_bit); // see [R1] see [R3]
        rx_use = rx_slot_sel && bit_free(rx_mask, rx_bit); // see [R4]
    end

endmodule : hdlc_slot_gate

//--- logic/hdlc_ds0_channel_select.sv
`timescale 1ns/1ns
// Summary of operation
// [R1] tx enable bit set routes transmit hdlc data into ds0 slots, not data link
// [R2] mode 0 uses the 5-bit channel number; mode 1 uses channel-block flags
// [R3] tx mask bit 7..0 covers ds0 bits 8..1; a one keeps that bit from hdlc
// [R4] rx mask register excludes ds0 bits from receive hdlc the same way
// [R5] hdlc stream uses only unmasked bits in order, pausing across masked ones
module hdlc_ds0_channel_select #(
    parameter int NUM_SLOTS = hdlc_slot_pkg::NUM_SLOTS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [hdlc_slot_pkg::ADDR_W-1:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [hdlc_slot_pkg::DATA_W-1:0] wdata,
    output logic [hdlc_slot_pkg::DATA_W-1:0] rdata,
    input wire logic [hdlc_slot_pkg::NUM_FRAMERS-1:0][NUM_SLOTS-1:0] tx_chan_block,
    input wire logic [hdlc_slot_pkg::NUM_FRAMERS-1:0][hdlc_slot_pkg::SLOT_W-1:0] tx_slot,
    input wire logic [hdlc_slot_pkg::NUM_FRAMERS-1:0][hdlc_slot_pkg::BIT_IDX_W-1:0] tx_bit,
    input wire logic [hdlc_slot_pkg::NUM_FRAMERS-1:0] tx_line_bit,
    input wire logic [hdlc_slot_pkg::NUM_FRAMERS-1:0] tx_hdlc_bit,
    output logic [hdlc_slot_pkg::NUM_FRAMERS-1:0] tx_out_bit,
    output logic [hdlc_slot_pkg::NUM_FRAMERS-1:0] tx_hdlc_take,
    input wire logic [hdlc_slot_pkg::NUM_FRAMERS-1:0] rx_slot_sel,
    input wire logic [hdlc_slot_pkg::NUM_FRAMERS-1:0][hdlc_slot_pkg::BIT_IDX_W-1:0] rx_bit,
    input wire logic [hdlc_slot_pkg::NUM_FRAMERS-1:0] rx_line_bit,
    output logic [hdlc_slot_pkg::NUM_FRAMERS-1:0] rx_hdlc_bit,
    output logic [hdlc_slot_pkg::NUM_FRAMERS-1:0] rx_hdlc_take
);

    localparam int NF = hdlc_slot_pkg::NUM_FRAMERS;
    localparam int DW = hdlc_slot_pkg::DATA_W;

    typedef struct packed {
        logic [NF-1:0][DW-1:0] tx_ctrl;
        logic [NF-1:0][DW-1:0] tx_mask;
        logic [NF-1:0][DW-1:0] rx_mask;
        logic [DW-1:0] rdata;
        logic [NF-1:0] tx_out;
        logic [NF-1:0] tx_take;
        logic [NF-1:0] rx_data;
        logic [NF-1:0] rx_take;
    } state_t;

    // ======================================================================
    // reset release
    // ======================================================================
    logic [1:0] rst_sync_r;
    logic rst_q_b;

    // async assert, two-flop release so every flop leaves reset together
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_q_b = rst_sync_r[1];

    // ======================================================================
    // slot decision per framer
    // ======================================================================
    state_t st_r;
    state_t st_nxt;
    logic [NF-1:0] tx_use;
    logic [NF-1:0] rx_use;
    logic [NF-1:0] tx_block_flag;

    // a slot number beyond the frame never matches a channel-block flag
    function automatic logic block_flag(input logic [NUM_SLOTS-1:0] flags,
                                        input logic [hdlc_slot_pkg::SLOT_W-1:0] slot);
        block_flag = 1'b0;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (slot == i[hdlc_slot_pkg::SLOT_W-1:0]) begin
                block_flag = flags[i];
            end
        end
    endfunction : block_flag

    for (genvar f = 0; f < NF; f++) begin : g_gate
        assign tx_block_flag[f] = block_flag(tx_chan_block[f], tx_slot[f]);
        hdlc_slot_gate u_gate (
            .tx_ctrl(st_r.tx_ctrl[f]),
            .tx_mask(st_r.tx_mask[f]),
            .rx_mask(st_r.rx_mask[f]),
            .tx_slot(tx_slot[f]),
            .tx_bit(tx_bit[f]),
            .tx_block_flag(tx_block_flag[f]),
            .rx_bit(rx_bit[f]),
            .rx_slot_sel(rx_slot_sel[f]),
            .tx_use(tx_use[f]),
            .rx_use(rx_use[f])
        );
    end

    // ======================================================================
    // register port and bit routing
    // ======================================================================
    // reads return the value held before a same-cycle write
    always_comb begin
        st_nxt = st_r;
        if (wr) begin
            unique case (addr)
                hdlc_slot_pkg::TX_CTRL_A_ADDR:
                    st_nxt.tx_ctrl[0] = wdata & hdlc_slot_pkg::TX_CTRL_WMASK;
                hdlc_slot_pkg::TX_CTRL_B_ADDR:
                    st_nxt.tx_ctrl[1] = wdata & hdlc_slot_pkg::TX_CTRL_WMASK;
                hdlc_slot_pkg::TX_MASK_A_ADDR: st_nxt.tx_mask[0] = wdata;
                hdlc_slot_pkg::TX_MASK_B_ADDR: st_nxt.tx_mask[1] = wdata;
                hdlc_slot_pkg::RX_MASK_A_ADDR: st_nxt.rx_mask[0] = wdata;
                hdlc_slot_pkg::RX_MASK_B_ADDR: st_nxt.rx_mask[1] = wdata;
                default: ; // unmapped writes are dropped
            endcase
        end
        if (rd) begin
            unique case (addr)
                hdlc_slot_pkg::TX_CTRL_A_ADDR: st_nxt.rdata = st_r.tx_ctrl[0];
                hdlc_slot_pkg::TX_CTRL_B_ADDR: st_nxt.rdata = st_r.tx_ctrl[1];
                hdlc_slot_pkg::TX_MASK_A_ADDR: st_nxt.rdata = st_r.tx_mask[0];
                hdlc_slot_pkg::TX_MASK_B_ADDR: st_nxt.rdata = st_r.tx_mask[1];
                hdlc_slot_pkg::RX_MASK_A_ADDR: st_nxt.rdata = st_r.rx_mask[0];
                hdlc_slot_pkg::RX_MASK_B_ADDR: st_nxt.rdata = st_r.rx_mask[1];
                default: st_nxt.rdata = hdlc_slot_pkg::UNMAPPED_READ;
            endcase
        end
        // masked or unselected bits keep line data; hdlc only advances on take
        for (int f = 0; f < NF; f++) begin
            st_nxt.tx_out[f] = tx_use[f] ? tx_hdlc_bit[f] : tx_line_bit[f]; // see [R1] see [R5]
            st_nxt.tx_take[f] = tx_use[f]; // see [R5]
            st_nxt.rx_data[f] = rx_line_bit[f];
            st_nxt.rx_take[f] = rx_use[f]; // see [R4] see [R5]
        end
    end

    // every output is a flop of the state struct
    always_ff @(posedge clk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            st_r <= '{tx_ctrl: {NF{hdlc_slot_pkg::REG_RESET}},
                      tx_mask: {NF{hdlc_slot_pkg::REG_RESET}},
                      rx_mask: {NF{hdlc_slot_pkg::REG_RESET}},
                      rdata: hdlc_slot_pkg::REG_RESET,
                      default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign tx_out_bit = st_r.tx_out;
    assign tx_hdlc_take = st_r.tx_take;
    assign rx_hdlc_bit = st_r.rx_data;
    assign rx_hdlc_take = st_r.rx_take;

    // ======================================================================
    // assertions on framer a
    // ======================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_q_b);

    a_tx_disabled_idle: assert property ( // see [R1]
        !st_r.tx_ctrl[0][hdlc_slot_pkg::TX_SLOT_HDLC_ENABLE_POS] |=> !tx_hdlc_take[0])
        else $error("hdlc took a bit while ds0 use disabled");

    a_single_slot_miss: assert property ( // see [R2]
        !st_r.tx_ctrl[0][hdlc_slot_pkg::TX_SLOT_SELECT_MODE_POS] &&
        tx_slot[0] != st_r.tx_ctrl[0][hdlc_slot_pkg::TX_CHANNEL_NUM_MSB_POS:
                                      hdlc_slot_pkg::TX_CHANNEL_NUM_LSB_POS]
        |=> !tx_hdlc_take[0])
        else $error("hdlc took a bit outside the numbered slot");

    a_block_slot_miss: assert property ( // see [R2]
        st_r.tx_ctrl[0][hdlc_slot_pkg::TX_SLOT_SELECT_MODE_POS] && !tx_block_flag[0]
        |=> !tx_hdlc_take[0])
        else $error("hdlc took a bit in an unflagged slot");

    a_single_slot_hit: assert property ( // see [R1]
        st_r.tx_ctrl[0][hdlc_slot_pkg::TX_SLOT_HDLC_ENABLE_POS] &&
        !st_r.tx_ctrl[0][hdlc_slot_pkg::TX_SLOT_SELECT_MODE_POS] &&
        tx_slot[0] == st_r.tx_ctrl[0][hdlc_slot_pkg::TX_CHANNEL_NUM_MSB_POS:
                                      hdlc_slot_pkg::TX_CHANNEL_NUM_LSB_POS] &&
        !st_r.tx_mask[0][tx_bit[0]] |=> tx_hdlc_take[0])
        else $error("selected unmasked bit not given to hdlc");

    a_tx_bit_mask: assert property ( // see [R3]
        st_r.tx_mask[0][tx_bit[0]] |=> !tx_hdlc_take[0])
        else $error("masked transmit bit used by hdlc");

    a_rx_bit_mask: assert property ( // see [R4]
        st_r.rx_mask[0][rx_bit[0]] || !rx_slot_sel[0] |=> !rx_hdlc_take[0])
        else $error("masked receive bit passed to hdlc");

    a_stream_data: assert property ( // see [R5]
        tx_hdlc_take[0] |-> tx_out_bit[0] == $past(tx_hdlc_bit[0]))
        else $error("hdlc bit not placed on the line");

    // first cycle out of reset shows the cleared flop, not the line bit
    a_line_pass: assert property ( // see [R5]
        $past(rst_q_b) && !tx_hdlc_take[0] |-> tx_out_bit[0] == $past(tx_line_bit[0]))
        else $error("line bit overwritten outside hdlc positions");

    c_single_mode: cover property (
        tx_hdlc_take[0] && !st_r.tx_ctrl[0][hdlc_slot_pkg::TX_SLOT_SELECT_MODE_POS]);
    c_block_mode: cover property (
        tx_hdlc_take[0] && st_r.tx_ctrl[0][hdlc_slot_pkg::TX_SLOT_SELECT_MODE_POS]);
    c_stream_pause: cover property (tx_hdlc_take[0] ##1 !tx_hdlc_take[0] ##1 tx_hdlc_take[0]);
    c_rx_take: cover property (rx_hdlc_take[0] && st_r.rx_mask[0] != hdlc_slot_pkg::REG_RESET);

endmodule : hdlc_ds0_channel_select

//--- test/hdlc_host_model.sv
`timescale 1ns/1ns
// ==========================================================================
// host controller on the parallel control port
// ==========================================================================
module hdlc_host_model (
    input wire logic clk,
    output logic [hdlc_slot_pkg::ADDR_W-1:0] addr,
    output logic wr,
    output logic rd,
    output logic [hdlc_slot_pkg::DATA_W-1:0] wdata
);
    // bus quiet at time zero
    initial begin
        addr = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
    end

    // one strobe cycle; released lines flip so stale values never look valid
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask : access
endmodule : hdlc_host_model

//--- test/hdlc_ds0_channel_select_tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
// ==========================================================================
// random register setups followed by random slot traffic on both framers
// ==========================================================================
module hdlc_ds0_channel_select_tb;
    localparam int NF = hdlc_slot_pkg::NUM_FRAMERS;
    localparam int NS = hdlc_slot_pkg::NUM_SLOTS;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr, wdata, rdata, er, v;
    logic wr, rd, rd_d = 1'b0, chk = 1'b0, chk_d = 1'b0;
    logic [NF-1:0][NS-1:0] blk;
    logic [NF-1:0][4:0] tslot;
    logic [NF-1:0][2:0] tbit, rbit;
    logic [NF-1:0] tline, thb, tout, ttake, rsel, rline, rhb, rtake, ptake = '1;
    logic [7:0] ctl [NF], tmk [NF], rmk [NF], amap [8];
    logic [7:0] rq [$], sq [$], es;
    int seed = 32'h94d1d759;
    int n_fail = 0;
    int checks_done = 0;

    always #25 clk = ~clk;

    hdlc_host_model i_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata));

    hdlc_ds0_channel_select #(.NUM_SLOTS(NS)) i_dut (
        .clk(clk), .rst_b(rst_b), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
        .rdata(rdata), .tx_chan_block(blk), .tx_slot(tslot), .tx_bit(tbit),
        .tx_line_bit(tline), .tx_hdlc_bit(thb), .tx_out_bit(tout), .tx_hdlc_take(ttake),
        .rx_slot_sel(rsel), .rx_bit(rbit), .rx_line_bit(rline), .rx_hdlc_bit(rhb),
        .rx_hdlc_take(rtake)
    );

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        rq.push_back(e);
        i_host.access(1'b0, a, 8'h00);
    endtask : rreg

    // hdlc bit only advances after a take, as a real controller would
    task automatic drive_cycle();
        logic [NS-1:0] b;
        logic [4:0] s;
        logic [2:0] tk, rk;
        logic tl, rl, rs, hb, ut;
        logic [7:0] e;
        @(posedge clk);
        for (int f = 0; f < NF; f++) begin
            b = NS'($random(seed));
            s = ($random(seed) & 1) ? ctl[f][4:0] : 5'($random(seed));
            tk = 3'($random(seed));
            rk = 3'($random(seed));
            {tl, rl, rs} = 3'($random(seed));
            hb = ptake[f] ? 1'($random(seed)) : thb[f];
            ut = ctl[f][7] && (ctl[f][5] ? (s < NS && b[s]) : ctl[f][4:0] == s)
                && !tmk[f][tk];
            ptake[f] = ut;
            e[6+f] = ut ? hb : tl;
            e[4+f] = ut;
            e[2+f] = rl;
            e[f] = rs && !rmk[f][rk];
            blk[f] <= b;
            tslot[f] <= s;
            tbit[f] <= tk;
            rbit[f] <= rk;
            tline[f] <= tl;
            rline[f] <= rl;
            rsel[f] <= rs;
            thb[f] <= hb;
        end
        sq.push_back(e);
        chk <= 1'b1;
    endtask : drive_cycle

    // results land one edge after the request; looked at on the falling edge
    always @(posedge clk) begin
        rd_d <= rd;
        chk_d <= chk;
    end
    always @(negedge clk) begin
        if (rd_d) begin
            er = rq.pop_front();
            `CHK("rdata", er, rdata)
        end
        if (chk_d) begin
            es = sq.pop_front();
            `CHK("tx_hdlc_take", es[5:4], ttake)
            `CHK("tx_out_bit", es[7:6], tout)
            `CHK("rx_hdlc_take", es[1:0], rtake)
            `CHK("rx_hdlc_bit", es[3:2], rhb)
        end
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        give_verdict();
    end

    initial begin
        {blk, tslot, tbit, rbit, tline, thb, rsel, rline} = '0;
        amap = '{hdlc_slot_pkg::RX_MASK_A_ADDR, hdlc_slot_pkg::TX_CTRL_A_ADDR,
            hdlc_slot_pkg::TX_MASK_A_ADDR, hdlc_slot_pkg::RX_MASK_B_ADDR,
            hdlc_slot_pkg::TX_CTRL_B_ADDR, hdlc_slot_pkg::TX_MASK_B_ADDR, 8'h94, 8'h90};
        repeat (11) @(posedge clk);
        @(negedge clk);
        `CHK("reset_out", 8'h00, {tout, ttake, rhb, rtake})
        @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 8; i++) rreg(amap[i], hdlc_slot_pkg::REG_RESET);
        for (int r = 0; r < 16; r++) begin
            for (int f = 0; f < NF; f++) begin
                v = 8'($random(seed)) | {r[1], 7'h00};
                ctl[f] = v & hdlc_slot_pkg::TX_CTRL_WMASK;
                tmk[f] = 8'($random(seed));
                rmk[f] = 8'($random(seed));
                i_host.access(1'b1, amap[3*f+1], v);
                i_host.access(1'b1, amap[3*f+2], tmk[f]);
                i_host.access(1'b1, amap[3*f], rmk[f]);
            end
            // unmapped write must leave everything alone
            i_host.access(1'b1, 8'h94, 8'($random(seed)));
            for (int i = 0; i < 8; i++) begin
                er = i > 5 ? 8'h00 : i % 3 == 0 ? rmk[i/3] : i % 3 == 1 ? ctl[i/3] : tmk[i/3];
                rreg(amap[i], er);
            end
            repeat (40) drive_cycle();
            @(posedge clk);
            chk <= 1'b0;
        end
        // mid-run reset: outputs drop at once, registers come back cleared
        @(posedge clk);
        rst_b <= 1'b0;
        @(negedge clk);
        `CHK("reset_mid", 8'h00, {tout, ttake, rhb, rtake})
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 8; i++) rreg(amap[i], hdlc_slot_pkg::REG_RESET);
        repeat (3) @(posedge clk);
        give_verdict();
    end
endmodule : hdlc_ds0_channel_select_tb
